// [rtl/pdp_pkg.sv]
package pdp_pkg;

  localparam int PDP_NPORT = 16;
  localparam int PDP_NPIN = 64;

  // Kinds of internal bus access issued by memory manipulation instructions
  typedef enum logic [3:0] {
    PDP_RD1 = 4'h0,
    PDP_RD4 = 4'h1,
    PDP_RD8 = 4'h2,
    PDP_WR4 = 4'h3,
    PDP_WR8 = 4'h4,
    PDP_BIT_SET_INSTRUCTION = 4'h5,
    PDP_BIT_CLEAR_INSTRUCTION = 4'h6
  } pdp_kind_t;

  typedef enum logic {
    PDP_SP_PORT = 1'b0,
    PDP_SP_REG = 1'b1
  } pdp_space_t;

  typedef struct packed {
    pdp_kind_t kind;
    pdp_space_t space;
    logic [3:0] addr;
    logic [1:0] bitsel;
    logic [7:0] wdata;
  } pdp_acc_t;

  // Register selects in the register space
  localparam logic [3:0] PDP_REG_DIR_A = 4'h0;
  localparam logic [3:0] PDP_REG_DIR_B = 4'h1;
  localparam logic [3:0] PDP_REG_DIR_C = 4'h2;
  localparam logic [3:0] PDP_REG_PU_A = 4'h3;

  // Values after reset
  localparam logic [7:0] PDP_DIR_RST = 8'h00;
  localparam logic [7:0] PDP_PU_RST = 8'h00;
  localparam logic [3:0] PDP_LATCH_RST = 4'h0;
  localparam logic [7:0] PDP_RD_RST = 8'h00;

  // Field positions in the direction registers
  localparam int PDP_A_P3_LO = 0;
  localparam int PDP_A_P6_LO = 4;
  localparam int PDP_B_P8 = 0;
  localparam int PDP_B_P2 = 2;
  localparam int PDP_B_P4 = 4;
  localparam int PDP_B_P5 = 5;
  localparam int PDP_B_P7 = 7;
  localparam int PDP_C_P9 = 1;
  localparam int PDP_C_P10 = 2;
  localparam int PDP_C_P11 = 3;
  localparam int PDP_C_P12 = 4;
  localparam int PDP_C_P13 = 5;
  localparam int PDP_C_P14 = 6;
  localparam int PDP_C_P15 = 7;

  // Ports able to drive; ports 0, 1, 8 and 15 are input only
  localparam logic [15:0] PDP_IO_MASK = 16'h7EFC;
  // Ports with a software pull-up group bit
  localparam logic [15:0] PDP_PU_MASK = 16'h00CF;

endpackage

// [rtl/pdp_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pdp_sync
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PDP_NPIN-1:0] din,
  output logic [PDP_NPIN-1:0] dout
);

  logic [PDP_NPIN-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// [rtl/pdp_port_cell.sv]
`timescale 1ns/100ps
`default_nettype none
module pdp_port_cell
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic io_en,
  input wire logic [3:0] dir,
  input wire logic wr_en,
  input wire logic [3:0] wr_data,
  input wire logic [3:0] pin_val,
  output logic [3:0] latch_ff,
  output logic [3:0] oe_ff,
  output logic [3:0] rd_val
);

  logic [3:0] eff_dir;

  assign eff_dir = io_en ? dir : 4'h0;

  // Output pins read back their latch, input pins their level
  assign rd_val = (eff_dir & latch_ff) | (~eff_dir & pin_val);

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= PDP_LATCH_RST;
    end else if (wr_en && io_en) begin
      latch_ff <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_ff <= 4'h0;
    end else begin
      oe_ff <= eff_dir;
    end
  end

endmodule
`default_nettype wire

// [rtl/pdp_top.sv]
// What this block does
// - Direction bit 0 makes a port an input, 1 an output with driver on.
// - Direction registers A, B, C load only from 8-bit writes.
// - Reset clears all direction bits: drivers off, every port an input.
// - Reads and bit tests of an input port return the pin levels.
// - Reads and bit tests of an output port return the output latch.
// - Nibble or byte write to an input port only updates the latch.
// - Nibble or byte write to an output port latches and drives pins.
// - Bit set or clear on an input port loads the latch with the pin levels, that bit changed.
// - Bit set or clear on an output port changes only that pin.
// - Pull-up bits 0,1,2,3,6,7 cover ports 0 (pins 1-3),1,2,3,6,7.
// - The interrupt 4 pin of port 0 never gets a pull-up.
// - Pull-up bit 0 means no pull-ups, 1 pulls up the whole group.
// - Port 9 direction is one bit, bit 1 of group C.
// - Ports 3 and 6 take one direction bit per pin from group A.
// - Ports 0, 1, 8, 15 are input only, always readable, no direction.
`timescale 1ns/100ps
`default_nettype none
module pdp_top
  import pdp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic ACC_VALID,
  input wire pdp_acc_t ACC_REQ,
  input wire logic [PDP_NPIN-1:0] PIN_IN,
  output logic [PDP_NPIN-1:0] PIN_OUT,
  output logic [PDP_NPIN-1:0] PIN_OE,
  output logic [PDP_NPIN-1:0] PIN_PULLUP,
  output logic [7:0] RD_DATA,
  output logic RD_VALID
);

  logic [7:0] dir_a_ff;
  logic [7:0] dir_b_ff;
  logic [7:0] dir_c_ff;
  logic [7:0] pu_a_ff;
  logic [PDP_NPIN-1:0] pin_sync;
  logic [3:0] rd_nib [PDP_NPORT];
  logic reg_wr;
  logic port_acc;

  // Direction nibble of one port from the three direction registers
  function automatic logic [3:0] dir_of(input int p, input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c);
    logic [3:0] d;
    d = 4'h0;
    case (p)
      2: d = {4{b[PDP_B_P2]}};
      3: d = a[PDP_A_P3_LO +: 4];
      4: d = {4{b[PDP_B_P4]}};
      5: d = {4{b[PDP_B_P5]}};
      6: d = a[PDP_A_P6_LO +: 4];
      7: d = {4{b[PDP_B_P7]}};
      9: d = {4{c[PDP_C_P9]}};
      10: d = {4{c[PDP_C_P10]}};
      11: d = {4{c[PDP_C_P11]}};
      12: d = {4{c[PDP_C_P12]}};
      13: d = {4{c[PDP_C_P13]}};
      14: d = {4{c[PDP_C_P14]}};
      default: d = 4'h0;
    endcase
    return d;
  endfunction

  // Whether a port-space write reaches port p
  function automatic logic port_written(input pdp_acc_t r, input int p);
    logic hit;
    hit = 1'b0;
    case (r.kind)
      PDP_WR4, PDP_BIT_SET_INSTRUCTION, PDP_BIT_CLEAR_INSTRUCTION: hit = (r.addr == 4'(p));
      PDP_WR8: hit = (r.addr[3:1] == 3'(p >> 1));
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign port_acc = ACC_VALID && (ACC_REQ.space == PDP_SP_PORT);
  assign reg_wr = ACC_VALID && (ACC_REQ.space == PDP_SP_REG) &&
                  (ACC_REQ.kind == PDP_WR8);

  pdp_sync u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .din(PIN_IN),
    .dout(pin_sync)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dir_a_ff <= PDP_DIR_RST;
      dir_b_ff <= PDP_DIR_RST;
      dir_c_ff <= PDP_DIR_RST;
    end else if (reg_wr) begin
      case (ACC_REQ.addr)
        PDP_REG_DIR_A: dir_a_ff <= ACC_REQ.wdata;
        PDP_REG_DIR_B: dir_b_ff <= ACC_REQ.wdata;
        PDP_REG_DIR_C: dir_c_ff <= ACC_REQ.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pu_a_ff <= PDP_PU_RST;
    end else if (reg_wr && ACC_REQ.addr == PDP_REG_PU_A) begin
      pu_a_ff <= ACC_REQ.wdata;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PDP_NPORT; gp++) begin : g_port
      logic [3:0] nxt_latch;
      logic wr_hit;

      assign wr_hit = port_acc && port_written(ACC_REQ, gp);

      always_comb begin
        nxt_latch = rd_nib[gp];
        case (ACC_REQ.kind)
          PDP_WR4: nxt_latch = ACC_REQ.wdata[3:0];
          PDP_WR8: nxt_latch = (gp % 2 == 1) ? ACC_REQ.wdata[7:4] :
                                       ACC_REQ.wdata[3:0];
          // Read-modify-write: input pins copy their level
          PDP_BIT_SET_INSTRUCTION: nxt_latch[ACC_REQ.bitsel] = 1'b1;
          PDP_BIT_CLEAR_INSTRUCTION: nxt_latch[ACC_REQ.bitsel] = 1'b0;
          default: nxt_latch = rd_nib[gp];
        endcase
      end

      pdp_port_cell u_cell (
        .clk(CORE_CLK),
        .rst(RST),
        .io_en(PDP_IO_MASK[gp]),
        .dir(dir_of(gp, dir_a_ff, dir_b_ff, dir_c_ff)),
        .wr_en(wr_hit),
        .wr_data(nxt_latch),
        .pin_val(pin_sync[4*gp +: 4]),
        .latch_ff(PIN_OUT[4*gp +: 4]),
        .oe_ff(PIN_OE[4*gp +: 4]),
        .rd_val(rd_nib[gp])
      );
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PIN_PULLUP <= '0;
    end else begin
      for (int i = 0; i < PDP_NPIN; i++) begin
        PIN_PULLUP[i] <= PDP_PU_MASK[i/4] && pu_a_ff[(i/4) % 8];
      end
      PIN_PULLUP[0] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= ACC_VALID && (ACC_REQ.kind == PDP_RD1 ||
                                ACC_REQ.kind == PDP_RD4 ||
                                ACC_REQ.kind == PDP_RD8);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RD_DATA <= PDP_RD_RST;
    end else if (ACC_VALID && ACC_REQ.space == PDP_SP_REG) begin
      case (ACC_REQ.addr)
        PDP_REG_DIR_A: RD_DATA <= dir_a_ff;
        PDP_REG_DIR_B: RD_DATA <= dir_b_ff;
        PDP_REG_DIR_C: RD_DATA <= dir_c_ff;
        PDP_REG_PU_A: RD_DATA <= pu_a_ff;
        default: RD_DATA <= 8'h00;
      endcase
    end else if (ACC_VALID) begin
      case (ACC_REQ.kind)
        PDP_RD1: RD_DATA <= {7'h00, rd_nib[ACC_REQ.addr][ACC_REQ.bitsel]};
        PDP_RD4: RD_DATA <= {4'h0, rd_nib[ACC_REQ.addr]};
        PDP_RD8: RD_DATA <= {rd_nib[{ACC_REQ.addr[3:1], 1'b1}],
                             rd_nib[{ACC_REQ.addr[3:1], 1'b0}]};
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_wr4_p2;
    ACC_VALID && ACC_REQ.space == PDP_SP_PORT &&
    ACC_REQ.kind == PDP_WR4 && ACC_REQ.addr == 4'h2;
  endsequence

  sequence s_bit_p2_out;
    ACC_VALID && ACC_REQ.space == PDP_SP_PORT && dir_b_ff[PDP_B_P2] &&
    ACC_REQ.kind == PDP_BIT_SET_INSTRUCTION && ACC_REQ.addr == 4'h2;
  endsequence

  sequence s_rd4(logic [3:0] p);
    ACC_VALID && ACC_REQ.space == PDP_SP_PORT &&
    ACC_REQ.kind == PDP_RD4 && ACC_REQ.addr == p;
  endsequence

  sequence s_reg_wr8(logic [3:0] r);
    ACC_VALID && ACC_REQ.space == PDP_SP_REG &&
    ACC_REQ.kind == PDP_WR8 && ACC_REQ.addr == r;
  endsequence

  sequence s_port_op(pdp_kind_t k, logic [3:0] p);
    ACC_VALID && ACC_REQ.space == PDP_SP_PORT &&
    ACC_REQ.kind == k && ACC_REQ.addr == p;
  endsequence

  chk_mode_reset: assert property (
    $fell(RST) |-> dir_a_ff == 8'h00 && dir_b_ff == 8'h00 &&
                   dir_c_ff == 8'h00 && PIN_OE == '0)
    else $error("direction state not cleared by reset");

  chk_reg_only8: assert property (
    ACC_VALID && ACC_REQ.space == PDP_SP_REG && ACC_REQ.kind != PDP_WR8
    |=> $stable(dir_a_ff) && $stable(dir_b_ff) && $stable(dir_c_ff))
    else $error("direction register changed by non byte write");

  chk_input_only: assert property (
    PIN_OE[7:0] == 8'h00 && PIN_OE[35:32] == 4'h0 && PIN_OE[63:60] == 4'h0)
    else $error("input only port driven");

  chk_p3_perpin: assert property (
    ##1 PIN_OE[15:12] == $past(dir_a_ff[3:0]))
    else $error("port 3 enables do not follow group A");

  chk_p9_dir: assert property (
    ##1 PIN_OE[39:36] == {4{$past(dir_c_ff[PDP_C_P9])}})
    else $error("port 9 enable does not follow group C bit 1");

  chk_rd_pins: assert property (
    s_rd4(4'h0) |=> RD_VALID && RD_DATA == {4'h0, $past(pin_sync[3:0])})
    else $error("input port read not pin level");

  chk_rd_latch: assert property (
    s_rd4(4'h2) and dir_b_ff[PDP_B_P2]
    |=> RD_DATA[3:0] == $past(PIN_OUT[11:8]))
    else $error("output port read not latch");

  chk_wr_latch: assert property (
    s_wr4_p2 |=> PIN_OUT[11:8] == $past(ACC_REQ.wdata[3:0])
             ##1 PIN_OE[11:8] == {4{$past(dir_b_ff[PDP_B_P2], 2)}})
    else $error("nibble write not latched or driven");

  chk_bit_set: assert property (
    s_bit_p2_out |=> PIN_OUT[4'h8 + $past(ACC_REQ.bitsel)] &&
      ((PIN_OUT[11:8] ^ $past(PIN_OUT[11:8])) &
       ~(4'h1 << $past(ACC_REQ.bitsel))) == 4'h0)
    else $error("bit set touched other pins");

  chk_pull_external_interrupt_4: assert property (
    !PIN_PULLUP[0])
    else $error("interrupt 4 pin pulled up");

  chk_pull_grp: assert property (
    ##1 PIN_PULLUP[7:4] == {4{$past(pu_a_ff[1])}} &&
        PIN_PULLUP[27:24] == {4{$past(pu_a_ff[6])}} &&
        PIN_PULLUP[3:1] == {3{$past(pu_a_ff[0])}} &&
        PIN_PULLUP[19:16] == 4'h0)
    else $error("pull-up group mismatch");

  chk_reset_rest: assert property (
    $fell(RST) |-> PIN_OUT == '0 && PIN_PULLUP == '0 && pu_a_ff == 8'h00)
    else $error("latches or pull-ups not cleared by reset");

  chk_rd_answer: assert property (
    ACC_VALID && ACC_REQ.kind inside {PDP_RD1, PDP_RD4, PDP_RD8}
    |=> RD_VALID)
    else $error("read not answered after one cycle");

  chk_rd_quiet: assert property (
    !(ACC_VALID && ACC_REQ.kind inside {PDP_RD1, PDP_RD4, PDP_RD8})
    |=> !RD_VALID)
    else $error("read answer without a read");

  chk_dir_a_load: assert property (
    s_reg_wr8(PDP_REG_DIR_A) |=> dir_a_ff == $past(ACC_REQ.wdata))
    else $error("group A not loaded by byte write");

  chk_dir_b_load: assert property (
    s_reg_wr8(PDP_REG_DIR_B) |=> dir_b_ff == $past(ACC_REQ.wdata))
    else $error("group B not loaded by byte write");

  chk_dir_c_load: assert property (
    s_reg_wr8(PDP_REG_DIR_C) |=> dir_c_ff == $past(ACC_REQ.wdata))
    else $error("group C not loaded by byte write");

  chk_pu_load: assert property (
    s_reg_wr8(PDP_REG_PU_A) |=> pu_a_ff == $past(ACC_REQ.wdata))
    else $error("pull-up register not loaded by byte write");

  chk_p6_perpin: assert property (
    ##1 PIN_OE[27:24] == $past(dir_a_ff[7:4]))
    else $error("port 6 enables do not follow group A");

  chk_group_dirs: assert property (
    ##1 PIN_OE[11:8] == {4{$past(dir_b_ff[PDP_B_P2])}} &&
        PIN_OE[59:56] == {4{$past(dir_c_ff[PDP_C_P14])}})
    else $error("port enables do not follow their direction bit");

  chk_wr_input: assert property (
    s_port_op(PDP_WR4, 4'h2) ##0 !dir_b_ff[PDP_B_P2]
    |=> PIN_OUT[11:8] == $past(ACC_REQ.wdata[3:0]) && PIN_OE[11:8] == 4'h0)
    else $error("input mode write drove pins or missed latch");

  chk_wr_output: assert property (
    s_port_op(PDP_WR4, 4'h2) ##0 dir_b_ff[PDP_B_P2]
    |=> PIN_OUT[11:8] == $past(ACC_REQ.wdata[3:0]) && PIN_OE[11:8] == 4'hF)
    else $error("output mode write not driven");

  chk_wr8_pair: assert property (
    s_port_op(PDP_WR8, 4'h2) |=> PIN_OUT[15:8] == $past(ACC_REQ.wdata))
    else $error("byte write did not reach both ports of the pair");

  chk_wr_ignored: assert property (
    s_port_op(PDP_WR4, 4'h8) |=> $stable(PIN_OUT[35:32]))
    else $error("input only port latch written");

  chk_bit_clear: assert property (
    s_port_op(PDP_BIT_CLEAR_INSTRUCTION, 4'h2) ##0 dir_b_ff[PDP_B_P2]
    |=> !PIN_OUT[4'h8 + $past(ACC_REQ.bitsel)] &&
      ((PIN_OUT[11:8] ^ $past(PIN_OUT[11:8])) &
       ~(4'h1 << $past(ACC_REQ.bitsel))) == 4'h0)
    else $error("bit clear touched other pins");

  chk_rd1_latch: assert property (
    s_port_op(PDP_RD1, 4'h2) ##0 dir_b_ff[PDP_B_P2]
    |=> RD_DATA == {7'h00, $past(PIN_OUT[4'h8 + ACC_REQ.bitsel])})
    else $error("bit test of output port not latch");

  chk_rd8_pair: assert property (
    s_port_op(PDP_RD8, 4'h3) ##0 dir_b_ff[PDP_B_P2] ##0 dir_a_ff[3:0] == 4'h0
    |=> RD_DATA == {$past(pin_sync[15:12]), $past(PIN_OUT[11:8])})
    else $error("byte read of port pair wrong");

  chk_reg_readback: assert property (
    ACC_VALID && ACC_REQ.space == PDP_SP_REG &&
    ACC_REQ.addr == PDP_REG_DIR_B |=> RD_DATA == $past(dir_b_ff))
    else $error("group B read back wrong");

  chk_pull_mid: assert property (
    ##1 PIN_PULLUP[15:12] == {4{$past(pu_a_ff[3])}} &&
        PIN_PULLUP[11:8] == {4{$past(pu_a_ff[2])}} &&
        PIN_PULLUP[31:28] == {4{$past(pu_a_ff[7])}})
    else $error("pull-ups of ports 2, 3 or 7 wrong");

endmodule
`default_nettype wire

// [tb/pdp_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pdp_pins_model
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic [PDP_NPIN-1:0] pin_out,
  input wire logic [PDP_NPIN-1:0] pin_oe,
  input wire logic [PDP_NPIN-1:0] pin_pullup,
  input wire logic [PDP_NPIN-1:0] ext_val,
  input wire logic [PDP_NPIN-1:0] ext_en,
  output logic [PDP_NPIN-1:0] pin_in
);
  // A strong outside source wins over the pin driver, so a read shows
  // whether it took the latch or the pin; a floating pin keeps toggling
  logic [PDP_NPIN-1:0] float_ff = '0;
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  assign pin_in = (ext_en & ext_val) | (~ext_en & pin_oe & pin_out) |
    (~ext_en & ~pin_oe & (pin_pullup | float_ff));
endmodule
`default_nettype wire

// [tb/pdp_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module pdp_top_test
  import pdp_pkg::*;
();
  typedef struct {
    pdp_kind_t k;
    pdp_space_t s;
    logic [3:0] a;
    logic [1:0] b;
    logic [7:0] w;
    logic c;
    logic [7:0] e;
  } pdp_row_t;
  localparam pdp_space_t sp = PDP_SP_PORT;
  localparam pdp_space_t sr = PDP_SP_REG;
  logic core_clk, rst, acc_valid, rd_valid;
  pdp_acc_t acc_req;
  logic [63:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val, ext_en;
  logic [7:0] rd_data, rd;
  int failures, n_compared;
  pdp_row_t rows[$];

  pdp_top i_dut (.CORE_CLK(core_clk), .RST(rst), .ACC_VALID(acc_valid),
    .ACC_REQ(acc_req), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pullup), .RD_DATA(rd_data), .RD_VALID(rd_valid));
  pdp_pins_model i_pins (.clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One access from a falling edge, then three idle cycles
  task automatic acc(input pdp_kind_t k, input pdp_space_t s,
    input logic [3:0] a, input logic [1:0] b, input logic [7:0] w);
    int i;
    acc_req = '{kind: k, space: s, addr: a, bitsel: b, wdata: w};
    acc_valid = 1'b1;
    @(negedge core_clk);
    acc_valid = 1'b0;
    if (k inside {PDP_RD1, PDP_RD4, PDP_RD8}) begin
      for (i = 0; i < 4 && rd_valid !== 1'b1; i++)
        @(negedge core_clk);
      if (rd_valid !== 1'b1) begin
        failures++;
        final_report();
      end
      rd = rd_data;
    end
    repeat (3) @(negedge core_clk);
  endtask

  task automatic add(input pdp_kind_t k, input pdp_space_t s,
    input logic [3:0] a, input logic [1:0] b, input logic [7:0] w,
    input logic c, input logic [7:0] e);
    rows.push_back('{k, s, a, b, w, c, e});
  endtask

  task automatic chk_reset();
    int r;
    check(pin_oe, 64'h0);
    check(pin_pullup, 64'h0);
    for (r = 0; r < 4; r++) begin
      acc(PDP_RD8, sr, 4'(r), 2'h0, 8'h00);
      check(64'(rd), 64'h0);
    end
    $display("test reset done");
  endtask

  initial begin
    rst = 1'b1;
    acc_valid = 1'b0;
    acc_req = '0;
    ext_val = {16{4'h5}};
    ext_en = '1;
    failures = 0;
    n_compared = 0;
    rd = 8'h00;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    chk_reset();
    add(PDP_RD4, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h05);
    add(PDP_WR4, sp, 4'h2, 2'h0, 8'h03, 1'b0, 8'h00);
    add(PDP_WR8, sr, 4'h1, 2'h0, 8'h04, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h03);
    add(PDP_WR4, sp, 4'h2, 2'h0, 8'h09, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h09);
    add(PDP_BIT_SET_INSTRUCTION, sp, 4'h2, 2'h2, 8'h00, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h0D);
    add(PDP_BIT_CLEAR_INSTRUCTION, sp, 4'h2, 2'h3, 8'h00, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h05);
    add(PDP_RD1, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h01);
    add(PDP_RD8, sp, 4'h2, 2'h0, 8'h00, 1'b1, 8'h55);
    add(PDP_WR8, sp, 4'h2, 2'h0, 8'h3A, 1'b0, 8'h00);
    add(PDP_RD8, sp, 4'h3, 2'h0, 8'h00, 1'b1, 8'h5A);
    add(PDP_WR4, sp, 4'h0, 2'h0, 8'h0A, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h0, 2'h0, 8'h00, 1'b1, 8'h05);
    add(PDP_WR4, sp, 4'h8, 2'h0, 8'h0A, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h8, 2'h0, 8'h00, 1'b1, 8'h05);
    add(PDP_WR8, sr, 4'h0, 2'h0, 8'h05, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h3, 2'h0, 8'h00, 1'b1, 8'h01);
    add(PDP_WR4, sp, 4'h9, 2'h0, 8'h0C, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h9, 2'h0, 8'h00, 1'b1, 8'h05);
    add(PDP_WR8, sr, 4'h2, 2'h0, 8'h02, 1'b0, 8'h00);
    add(PDP_RD4, sp, 4'h9, 2'h0, 8'h00, 1'b1, 8'h0C);
    add(PDP_WR4, sr, 4'h1, 2'h0, 8'h00, 1'b0, 8'h00);
    add(PDP_RD8, sr, 4'h1, 2'h0, 8'h00, 1'b1, 8'h04);
    add(PDP_RD8, sr, 4'h7, 2'h0, 8'h00, 1'b1, 8'h00);
    add(PDP_WR8, sr, 4'h3, 2'h0, 8'hFF, 1'b0, 8'h00);
    add(PDP_RD8, sr, 4'h3, 2'h0, 8'h00, 1'b1, 8'hFF);
    foreach (rows[i]) begin
      acc(rows[i].k, rows[i].s, rows[i].a, rows[i].b, rows[i].w);
      if (rows[i].c)
        check(64'(rd), 64'(rows[i].e));
    end
    $display("test rows done");
    check(pin_oe, 64'h0000_00F0_0000_5F00);
    check(64'(pin_out[11:8]), 64'hA);
    check(pin_pullup, 64'h0000_0000_FF00_FFFE);
    ext_en[7:4] = 4'h0;
    repeat (2) @(negedge core_clk);
    acc(PDP_RD4, sp, 4'h1, 2'h0, 8'h00);
    check(64'(rd), 64'h0F);
    acc(PDP_WR8, sr, 4'h3, 2'h0, 8'h01);
    check(pin_pullup, 64'h0000_0000_0000_000E);
    ext_en = '1;
    $display("test pull-ups done");
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk_reset();
    final_report();
  end
endmodule
`default_nettype wire
